// File: common/dtpb_map.svh
`ifndef DTPB_MAP_SVH
`define DTPB_MAP_SVH
// ----------------------------------------------------------------------
// register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------------
`define DTPB_UP_COUNT_OFF 12'h000
`define DTPB_UP_MODE_OFF 12'h004
`define DTPB_POWER_CTRL1_OFF 12'h008
`define DTPB_DN_COUNT_OFF 12'h00c
`define DTPB_DN_CTRL1_OFF 12'h010
`define DTPB_DN_CTRL2_OFF 12'h014
`define DTPB_PSC_VALUE_OFF 12'h018
`define DTPB_PWM_DUTY_OFF 12'h01c
`define DTPB_BUZZER_CTRL_OFF 12'h020
`define DTPB_IRQ_FLAG_OFF 12'h024
`define DTPB_IRQ_EN_OFF 12'h028
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define DTPB_UP_RUN_BIT 0
`define DTPB_GLOBAL_IRQ_BIT 7
`define DTPB_UP_LOWCLK_BIT 7
`define DTPB_UP_SRC_BIT 5
`define DTPB_UP_EDGE_BIT 4
`define DTPB_PSC_ASSIGN_BIT 3
`define DTPB_DN_RUN_BIT 0
`define DTPB_RELOAD_SEL_BIT 1
`define DTPB_ONE_SHOT_BIT 2
`define DTPB_PWM_AL_BIT 6
`define DTPB_PWM_OE_BIT 7
`define DTPB_DN_SRC_BIT 5
`define DTPB_DN_EDGE_BIT 4
`define DTPB_DN_PSC_EN_N_BIT 3
`define DTPB_BUZZER_EN_BIT 7
`define DTPB_UP_FLAG_BIT 0
`define DTPB_DN_FLAG_BIT 3
// ----------------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------------
`define DTPB_MODE_RESET 8'h08
`define DTPB_CTRL2_RESET 8'h08
`define DTPB_COUNT_TOP 8'hff
`define DTPB_COUNT_ZERO 8'h00
`endif

// File: common/dtpb_pkg.sv
package dtpb_pkg;
  // count source choice for the up timer
  typedef enum logic [1:0] {
    DTPB_SRC_ICLK = 2'b00,
    DTPB_SRC_EXT = 2'b01,
    DTPB_SRC_LOW = 2'b11
  } dtpb_src_e;
  // apb request bundle
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } dtpb_apb_req_s;
  // pad drive bundle for the shared pwm/buzzer pin
  typedef struct packed {
    logic pwm_oe;
    logic pwm_level;
    logic buzzer_oe;
    logic buzzer_level;
  } dtpb_pads_s;
endpackage : dtpb_pkg

// File: src/dtpb_timers.sv
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "dtpb_map.svh"
// Operation
// - up timer counts only while run bit set
// - write loads up count, read returns live
// - source: iclk, ext pin, or low oscillator
// - edge bit picks falling or rising edges
// - prescaler on up timer; write zero clears
// - 3-bit ratio, 1:2 through 1:256
// - sources synchronised; fast sources lose counts
// - overflow sets flag; irq when enabled
// - down write loads reload and counter
// - down runs when enabled; pin or iclk
// - down edge bit picks falling or rising
// - down prescaler, active low enable, readable
// - one-shot counts once then stops
// - continuous restarts from reload or 0xff
// - underflow sets flag; irq when enabled
// - pwm enable drives pin as output
// - polarity bit selects active low
// - duty zero never active, 0xff long
// - buzzer enable drives pin as output
// - buzzer source bit, then ratio division
// - pwm inactive until count equals duty
module dtpb_timers (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // count clock inputs
  input wire logic ext_count_clock,
  input wire logic low_osc_clock,
  // pin and interrupt outputs
  output dtpb_pkg::dtpb_pads_s pads,
  output logic irq
);
  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [7:0] up_count_q;     // live up count
  logic [7:0] up_mode_q;      // up timer mode
  logic [7:0] power_ctrl1_q;  // run and global irq
  logic [7:0] down_count_q;   // live down count
  logic [7:0] down_reload_q;  // reload value
  logic [7:0] ctrl1_q;        // down control 1
  logic [7:0] ctrl2_q;        // down control 2
  logic [7:0] duty_q;         // pwm duty
  logic [7:0] buzzer_ctrl_q;  // buzzer control
  logic [7:0] flag_q;         // interrupt flags
  logic [7:0] irq_en_q;       // interrupt enables
  logic [7:0] psc0_q;         // shared prescaler
  logic [7:0] psc1_q;         // down prescaler
  logic [7:0] bz_div_q;       // buzzer divider
  logic one_shot_done_q;      // one-shot has finished
  logic pwm_active_q;         // pwm frame state
  logic buzzer_q;             // buzzer square wave
  // synchronisers and edge history
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic low_s1_q, low_s2_q, low_s3_q;
  // apb strobes
  logic wr, rd_phase;
  assign wr = psel && penable && pwrite;
  assign rd_phase = psel && !penable;
  // ----------------------------------------------------------------------
  // synchronisers: first stage feeds only the second
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      low_s1_q <= 1'b0;
      low_s2_q <= 1'b0;
      low_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_count_clock;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      low_s1_q <= low_osc_clock;
      low_s2_q <= low_s1_q;
      low_s3_q <= low_s2_q;
    end
  end

  // ----------------------------------------------------------------------
  // source selection and edge detection
  // ----------------------------------------------------------------------
  logic ext_rise, ext_fall, low_rise, low_fall;
  assign ext_rise = ext_s2_q && !ext_s3_q;
  assign ext_fall = !ext_s2_q && ext_s3_q;
  assign low_rise = low_s2_q && !low_s3_q;
  assign low_fall = !low_s2_q && low_s3_q;
  dtpb_pkg::dtpb_src_e up_src;
  assign up_src = !up_mode_q[`DTPB_UP_SRC_BIT] ? dtpb_pkg::DTPB_SRC_ICLK :
                  (up_mode_q[`DTPB_UP_LOWCLK_BIT] ? dtpb_pkg::DTPB_SRC_LOW
                                                  : dtpb_pkg::DTPB_SRC_EXT);
  logic up_edge_fall, up_src_tick;
  assign up_edge_fall = up_mode_q[`DTPB_UP_EDGE_BIT];
  always_comb begin
    unique case (up_src)
      dtpb_pkg::DTPB_SRC_ICLK: up_src_tick = 1'b1;
      dtpb_pkg::DTPB_SRC_EXT: up_src_tick = up_edge_fall ? ext_fall : ext_rise;
      dtpb_pkg::DTPB_SRC_LOW: up_src_tick = up_edge_fall ? low_fall : low_rise;
      default: up_src_tick = 1'b0;
    endcase
  end
  logic dn_src_tick;
  assign dn_src_tick = !ctrl2_q[`DTPB_DN_SRC_BIT] ? 1'b1 :
                       (ctrl2_q[`DTPB_DN_EDGE_BIT] ? ext_fall : ext_rise);

  // ----------------------------------------------------------------------
  // prescaler ticks: ratio n gives 2^(n+1); tick when the count equals 2^(n+1)-1
  // ----------------------------------------------------------------------
  logic up_run, psc0_on, psc0_tick, up_tick;
  assign up_run = power_ctrl1_q[`DTPB_UP_RUN_BIT];
  assign psc0_on = !up_mode_q[`DTPB_PSC_ASSIGN_BIT];
  assign psc0_tick = up_src_tick && (psc0_q == ((8'h02 << up_mode_q[2:0]) - 8'h01));
  assign up_tick = up_run && (psc0_on ? psc0_tick : up_src_tick);
  logic dn_run, psc1_on, psc1_tick, dn_tick;
  assign dn_run = ctrl1_q[`DTPB_DN_RUN_BIT] && !one_shot_done_q;
  assign psc1_on = !ctrl2_q[`DTPB_DN_PSC_EN_N_BIT];
  assign psc1_tick = dn_src_tick && (psc1_q == ((8'h02 << ctrl2_q[2:0]) - 8'h01));
  assign dn_tick = dn_run && (psc1_on ? psc1_tick : dn_src_tick);
  // shared prescaler; cleared by a write that assigns it to the up timer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      psc0_q <= 8'h00;
    end else if (wr && paddr == `DTPB_UP_MODE_OFF && !pwdata[`DTPB_PSC_ASSIGN_BIT]) begin
      psc0_q <= 8'h00;
    end else if (up_run && psc0_on && up_src_tick) begin
      psc0_q <= psc0_tick ? 8'h00 : psc0_q + 8'h01;
    end
  end
  // down prescaler, readable by firmware
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      psc1_q <= 8'h00;
    end else if (dn_run && psc1_on && dn_src_tick) begin
      psc1_q <= psc1_tick ? 8'h00 : psc1_q + 8'h01;
    end
  end
  // ----------------------------------------------------------------------
  // up timer
  // ----------------------------------------------------------------------
  logic up_ovf;
  assign up_ovf = up_tick && (up_count_q == `DTPB_COUNT_TOP);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      up_count_q <= 8'h00;
    end else if (wr && paddr == `DTPB_UP_COUNT_OFF) begin
      up_count_q <= pwdata[7:0];
    end else if (up_tick) begin
      up_count_q <= up_count_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // down timer
  // ----------------------------------------------------------------------
  logic dn_unf;
  assign dn_unf = dn_tick && (down_count_q == `DTPB_COUNT_ZERO);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      down_count_q <= 8'h00;
      down_reload_q <= 8'h00;
    end else if (wr && paddr == `DTPB_DN_COUNT_OFF) begin
      down_count_q <= pwdata[7:0];
      down_reload_q <= pwdata[7:0];
    end else if (dn_unf) begin
      // one-shot parks at zero; continuous restarts
      if (!ctrl1_q[`DTPB_ONE_SHOT_BIT]) begin
        down_count_q <= ctrl1_q[`DTPB_RELOAD_SEL_BIT] ? down_reload_q
                                                      : `DTPB_COUNT_TOP;
      end
    end else if (dn_tick) begin
      down_count_q <= down_count_q - 8'h01;
    end
  end
  // one-shot completion, rearmed by loading the counter or rewriting control
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      one_shot_done_q <= 1'b0;
    end else if (wr && (paddr == `DTPB_DN_COUNT_OFF || paddr == `DTPB_DN_CTRL1_OFF)) begin
      one_shot_done_q <= 1'b0;
    end else if (dn_unf && ctrl1_q[`DTPB_ONE_SHOT_BIT]) begin
      one_shot_done_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // pwm: inactive from start, active at duty match until underflow
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwm_active_q <= 1'b0;
    end else if (!ctrl1_q[`DTPB_DN_RUN_BIT] || dn_unf) begin
      pwm_active_q <= 1'b0;
    end else if (duty_q != 8'h00 && down_count_q == duty_q) begin
      pwm_active_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // buzzer divider and toggle
  // ----------------------------------------------------------------------
  logic bz_src, bz_tick;
  assign bz_src = buzzer_ctrl_q[3] ? dn_unf : (dn_run && psc1_tick);
  assign bz_tick = bz_src && (bz_div_q == ((8'h01 << buzzer_ctrl_q[2:0]) - 8'h01));
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bz_div_q <= 8'h00;
      buzzer_q <= 1'b0;
    end else if (!buzzer_ctrl_q[`DTPB_BUZZER_EN_BIT]) begin
      bz_div_q <= 8'h00;
      buzzer_q <= 1'b0;
    end else if (bz_src) begin
      bz_div_q <= bz_tick ? 8'h00 : bz_div_q + 8'h01;
      if (bz_tick) begin
        buzzer_q <= !buzzer_q;
      end
    end
  end

  // pad outputs registered so they leave straight from flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pads <= '0;
    end else begin
      pads.pwm_oe <= ctrl1_q[`DTPB_PWM_OE_BIT];
      pads.pwm_level <= pwm_active_q ^ ctrl1_q[`DTPB_PWM_AL_BIT];
      pads.buzzer_oe <= buzzer_ctrl_q[`DTPB_BUZZER_EN_BIT];
      pads.buzzer_level <= buzzer_q;
    end
  end

  // ----------------------------------------------------------------------
  // flags: hardware set wins over firmware clear
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag_q <= 8'h00;
    end else begin
      if (wr && paddr == `DTPB_IRQ_FLAG_OFF) begin
        flag_q <= flag_q & pwdata[7:0];
      end
      if (up_ovf) begin
        flag_q[`DTPB_UP_FLAG_BIT] <= 1'b1;
      end
      if (dn_unf) begin
        flag_q[`DTPB_DN_FLAG_BIT] <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= power_ctrl1_q[`DTPB_GLOBAL_IRQ_BIT] && |(flag_q & irq_en_q & 8'h09);
    end
  end

  // ----------------------------------------------------------------------
  // control register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      up_mode_q <= `DTPB_MODE_RESET;
      power_ctrl1_q <= 8'h00;
      ctrl1_q <= 8'h00;
      ctrl2_q <= `DTPB_CTRL2_RESET;
      duty_q <= 8'h00;
      buzzer_ctrl_q <= 8'h00;
      irq_en_q <= 8'h00;
    end else if (wr) begin
      unique case (paddr)
        `DTPB_UP_MODE_OFF: up_mode_q <= pwdata[7:0];
        `DTPB_POWER_CTRL1_OFF: power_ctrl1_q <= pwdata[7:0];
        `DTPB_DN_CTRL1_OFF: ctrl1_q <= pwdata[7:0];
        `DTPB_DN_CTRL2_OFF: ctrl2_q <= pwdata[7:0];
        `DTPB_PWM_DUTY_OFF: duty_q <= pwdata[7:0];
        `DTPB_BUZZER_CTRL_OFF: buzzer_ctrl_q <= pwdata[7:0];
        `DTPB_IRQ_EN_OFF: irq_en_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // apb read path: data captured in setup, ready in access
  // ----------------------------------------------------------------------
  logic [7:0] rd_mux;
  logic known;
  always_comb begin
    known = 1'b1;
    unique case (paddr)
      `DTPB_UP_COUNT_OFF: rd_mux = up_count_q;
      `DTPB_UP_MODE_OFF: rd_mux = up_mode_q;
      `DTPB_POWER_CTRL1_OFF: rd_mux = power_ctrl1_q;
      `DTPB_DN_COUNT_OFF: rd_mux = down_count_q;
      `DTPB_DN_CTRL1_OFF: rd_mux = ctrl1_q;
      `DTPB_DN_CTRL2_OFF: rd_mux = ctrl2_q;
      `DTPB_PSC_VALUE_OFF: rd_mux = psc1_q;
      `DTPB_PWM_DUTY_OFF: rd_mux = duty_q;
      `DTPB_BUZZER_CTRL_OFF: rd_mux = buzzer_ctrl_q;
      `DTPB_IRQ_FLAG_OFF: rd_mux = flag_q;
      `DTPB_IRQ_EN_OFF: rd_mux = irq_en_q;
      default: begin
        rd_mux = 8'h00;
        known = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_phase;
      pslverr <= rd_phase && !known;
      if (rd_phase) begin
        prdata <= {24'h00_0000, rd_mux};
      end
    end
  end
  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  up_count_load_a: assert property (@(posedge clk) disable iff (!resetn)
    (wr && paddr == `DTPB_UP_COUNT_OFF) |=> up_count_q == $past(pwdata[7:0]))
    else $error("up count not loaded");
  up_count_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    (!up_run && !wr) |=> $stable(up_count_q)) else $error("up count moved while stopped");
  up_ovf_flag_a: assert property (@(posedge clk) disable iff (!resetn)
    up_ovf |=> flag_q[0]) else $error("overflow flag not set");
  dn_load_a: assert property (@(posedge clk) disable iff (!resetn)
    (wr && paddr == `DTPB_DN_COUNT_OFF) |=> down_reload_q == down_count_q)
    else $error("reload and count differ after load");
  dn_restart_a: assert property (@(posedge clk) disable iff (!resetn)
    (dn_unf && !wr && !ctrl1_q[2] && !ctrl1_q[1]) |=> down_count_q == 8'hff)
    else $error("restart not from top");
  one_shot_stop_a: assert property (@(posedge clk) disable iff (!resetn)
    (dn_unf && !wr && ctrl1_q[2]) |=> ##1 (!dn_tick && down_count_q == 8'h00))
    else $error("one-shot kept counting");
  dn_flag_set_a: assert property (@(posedge clk) disable iff (!resetn)
    dn_unf |=> flag_q[3]) else $error("underflow flag not set");
  pwm_pol_a: assert property (@(posedge clk) disable iff (!resetn)
    ##1 pads.pwm_level == ($past(pwm_active_q) ^ $past(ctrl1_q[6])))
    else $error("pwm polarity wrong");
  pwm_zero_a: assert property (@(posedge clk) disable iff (!resetn)
    (duty_q == 8'h00 && !pwm_active_q) |=> !pwm_active_q) else $error("duty zero went active");
  apb_ready_a: assert property (@(posedge clk) disable iff (!resetn)
    rd_phase |=> pready) else $error("no ready after setup");
  ovf_cover: cover property (@(posedge clk) disable iff (!resetn) up_ovf);
  unf_cover: cover property (@(posedge clk) disable iff (!resetn) dn_unf);
  pwm_cover: cover property (@(posedge clk) disable iff (!resetn) $rose(pwm_active_q));
  buzzer_cover: cover property (@(posedge clk) disable iff (!resetn) $rose(buzzer_q));
endmodule : dtpb_timers

// File: test/dtpb_pin_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// count pin model: slow edges that stand still between bursts
// ----------------------------------------------------------------
module dtpb_pin_model (
  // clock
  input wire logic clk,
  // count pins
  output logic ext_count_clock,
  output logic low_osc_clock
);
  // both pins idle low until a burst is asked for
  initial begin
    ext_count_clock = 1'b0;
    low_osc_clock = 1'b0;
  end
  // toggle one pin n times; four clocks per level keeps it far below the
  // instruction clock, so the synchroniser can never drop an edge
  task automatic edges(input logic sel, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clk);
      if (sel) begin
        low_osc_clock <= ~low_osc_clock;
      end else begin
        ext_count_clock <= ~ext_count_clock;
      end
    end
    repeat (4) @(posedge clk);
  endtask : edges
endmodule : dtpb_pin_model

// File: test/tb_dual_timer_pwm_buzzer.sv
`timescale 1ns/100ps
`include "dtpb_map.svh"
module tb_dual_timer_pwm_buzzer;
  // ----------------------------------------------------------------
  // signals and register addresses
  // ----------------------------------------------------------------
  logic clk;
  logic resetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_count_clock;
  logic low_osc_clock;
  dtpb_pkg::dtpb_pads_s pads;
  logic irq;
  int n_fail;
  int cmp_count;
  int hi; // pwm high cycles in a window
  int tg; // buzzer toggles in a window
  logic [31:0] rv; // last read data
  logic re; // last error response
  localparam logic [11:0] A_UC = `DTPB_UP_COUNT_OFF;
  localparam logic [11:0] A_UM = `DTPB_UP_MODE_OFF;
  localparam logic [11:0] A_PW = `DTPB_POWER_CTRL1_OFF;
  localparam logic [11:0] A_DC = `DTPB_DN_COUNT_OFF;
  localparam logic [11:0] A_C1 = `DTPB_DN_CTRL1_OFF;
  localparam logic [11:0] A_C2 = `DTPB_DN_CTRL2_OFF;
  localparam logic [11:0] A_PV = `DTPB_PSC_VALUE_OFF;
  localparam logic [11:0] A_DU = `DTPB_PWM_DUTY_OFF;
  localparam logic [11:0] A_BZ = `DTPB_BUZZER_CTRL_OFF;
  localparam logic [11:0] A_FL = `DTPB_IRQ_FLAG_OFF;
  localparam logic [11:0] A_EN = `DTPB_IRQ_EN_OFF;
  dtpb_timers dtpb_timers_i (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_count_clock(ext_count_clock), .low_osc_clock(low_osc_clock),
    .pads(pads), .irq(irq));
  dtpb_pin_model dtpb_pin_model_i (.clk(clk), .ext_count_clock(ext_count_clock),
    .low_osc_clock(low_osc_clock));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // bus, compare and report tasks
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20) begin
      n_fail++;
      summarize();
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input string s, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(s, e, rv);
  endtask : rdc
  // count increase between two reads whose captures lie k+3 edges apart
  task automatic gap(input logic [11:0] a, input int k, input logic [7:0] e, input string s);
    logic [7:0] v;
    apb(1'b0, a, 32'h0);
    v = rv[7:0];
    repeat (k) @(posedge clk);
    apb(1'b0, a, 32'h0);
    chk(s, {24'h0, e}, {24'h0, rv[7:0] - v});
  endtask : gap
  // sample the pads for n cycles
  task automatic watch(input int n);
    logic p;
    hi = 0;
    tg = 0;
    repeat (20) @(posedge clk);
    p = pads.buzzer_level;
    repeat (n) begin
      @(posedge clk);
      if (pads.pwm_level === 1'b1) hi++;
      if (pads.buzzer_level !== p) tg++;
      p = pads.buzzer_level;
    end
  endtask : watch
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rdc("mode reset", A_UM, 32'h08);
    rdc("ctrl2 reset", A_C2, 32'h08);
    rdc("up count reset", A_UC, 32'h00);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, re});
    chk("unmapped data", 32'h0, rv);
    $display("reset test done");
  endtask : t_reset
  task automatic t_up_count;
    wr(A_PW, 32'h00);
    wr(A_UC, 32'h10);
    repeat (10) @(posedge clk);
    rdc("held count", A_UC, 32'h10);
    wr(A_PW, 32'h01);
    gap(A_UC, 13, 8'd16, "iclk count");
    // prescaler ratio n divides by 2^(n+1); window scaled to give 8
    for (int n = 0; n < 3; n++) begin
      wr(A_UM, n);
      gap(A_UC, (8 << (n + 1)) - 3, 8'd8, "prescaled count");
    end
    $display("up count test done");
  endtask : t_up_count
  task automatic t_up_src;
    logic [7:0] m[4] = '{8'h28, 8'h38, 8'ha8, 8'hb8};
    logic [7:0] e[4] = '{8'h02, 8'h01, 8'h02, 8'h01};
    // the low source is never the instruction clock here, so firmware
    // may leave the prescaler unassigned
    for (int i = 0; i < 4; i++) begin
      wr(A_UM, {24'h0, m[i]});
      wr(A_UC, 32'h00);
      dtpb_pin_model_i.edges(i[1], 3);
      rdc("pin edges", A_UC, {24'h0, e[i]});
      dtpb_pin_model_i.edges(i[1], 1);
    end
    $display("up source test done");
  endtask : t_up_src
  task automatic t_up_flag;
    wr(A_EN, 32'h09);
    wr(A_UM, 32'h08);
    // stop first and clear flags left by earlier wraps, so only this overflow counts
    wr(A_PW, 32'h80);
    wr(A_UC, 32'hfe);
    wr(A_FL, 32'h00);
    rdc("no stale flag", A_FL, 32'h00);
    wr(A_PW, 32'h81);
    repeat (8) @(posedge clk);
    wr(A_PW, 32'h80);
    rdc("overflow flag", A_FL, 32'h01);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(A_FL, 32'h00);
    rdc("flag cleared", A_FL, 32'h00);
    chk("irq off", 32'h0, {31'h0, irq});
    $display("overflow test done");
  endtask : t_up_flag
  task automatic t_down;
    int mx;
    wr(A_DU, 32'h00);
    wr(A_DC, 32'h05);
    wr(A_C1, 32'h05);
    repeat (20) @(posedge clk);
    rdc("one shot end", A_DC, 32'h00);
    rdc("underflow flag", A_FL, 32'h08);
    chk("down irq", 32'h1, {31'h0, irq});
    repeat (10) @(posedge clk);
    rdc("one shot stays", A_DC, 32'h00);
    wr(A_FL, 32'h00);
    // free run from 0xff versus reload, told apart by the largest count seen
    for (int r = 0; r < 2; r++) begin
      wr(A_C1, r ? 32'h03 : 32'h01);
      wr(A_DC, 32'h05);
      mx = 0;
      repeat (8) begin
        apb(1'b0, A_DC, 32'h0);
        if (rv[7:0] > mx) mx = rv[7:0];
      end
      chk("restart value", r ? 32'h0 : 32'h1, {31'h0, mx > 5});
    end
    $display("down timer test done");
  endtask : t_down
  task automatic t_pwm;
    int h;
    // reload 5 gives a six-clock frame; duty 2 is active two clocks of it,
    // so a lost polarity inversion cannot balance out
    wr(A_DU, 32'h02);
    wr(A_C1, 32'h83);
    watch(420);
    h = hi;
    chk("pwm drive", 32'h1, {31'h0, pads.pwm_oe});
    chk("pwm active time", 32'd140, h);
    wr(A_C1, 32'hc3);
    watch(420);
    chk("pwm polarity", 32'd420, h + hi);
    wr(A_DU, 32'h00);
    wr(A_C1, 32'h83);
    watch(420);
    chk("duty zero", 32'h0, hi);
    $display("pwm test done");
  endtask : t_pwm
  task automatic t_buzz;
    int t;
    wr(A_C1, 32'h03);
    wr(A_BZ, 32'h88);
    watch(420);
    t = tg;
    chk("buzz drive", 32'h1, {31'h0, pads.buzzer_oe});
    wr(A_BZ, 32'h89);
    watch(420);
    chk("buzz ratio", 32'h1, {31'h0, tg > 0 && tg < t});
    wr(A_C2, 32'h00);
    wr(A_BZ, 32'h80);
    watch(420);
    chk("buzz prescaler", 32'h1, {31'h0, tg > 0});
    apb(1'b0, A_PV, 32'h0);
    t = rv;
    apb(1'b0, A_PV, 32'h0);
    chk("prescaler moves", 32'h1, {31'h0, rv != t});
    $display("buzzer test done");
  endtask : t_buzz
  // down timer fed from the pin: three toggles give two rises and one fall
  task automatic t_down_pin;
    for (int i = 0; i < 2; i++) begin
      wr(A_C2, i ? 32'h38 : 32'h28);
      wr(A_DC, 32'h10);
      dtpb_pin_model_i.edges(1'b0, 3);
      rdc("down pin edges", A_DC, i ? 32'h0f : 32'h0e);
      dtpb_pin_model_i.edges(1'b0, 1);
    end
    $display("down pin test done");
  endtask : t_down_pin
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    n_fail = 0;
    cmp_count = 0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_up_count();
    t_up_src();
    t_up_flag();
    t_down();
    t_pwm();
    t_buzz();
    t_down_pin();
    summarize();
  end
endmodule : tb_dual_timer_pwm_buzzer
